// File: rtl/sxd_decoder.sv
// registered decoder for stack pull and transfer instructions
// Overview of operation
// - 8f with middle field 000 pulls a memory word from stack, 24 clocks
// - 000 seg 111 pulls a segment register in 12 clocks; selector 01 illegal
// - 1000011 w swaps register with register or memory, 4 or 17 clocks
// - 8d loads effective offset in 26 clocks; register addressing form illegal
// - c4 far pointer load needs memory operand, 26 clocks
// - d7 table lookup replaces low accumulator byte, 15 clocks
// - 9f copies low flag byte into high accumulator byte, 2 clocks
// - 9e writes high accumulator byte into low flags, 3 clocks
`timescale 1ns/100ps
`default_nettype none
`include "sxd_defines.svh"
module sxd_decoder
  import sxd_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      nrst,
  input  wire logic      in_valid,
  input  wire sxd_insn_s in_insn,
  output logic           out_valid,
  output sxd_dec_s       out_dec,
  output logic           busy
);
  sxd_dec_s   dec_d;
  sxd_dec_s   dec_q;
  logic       valid_q;
  logic [5:0] cnt_q;

  ////////////////////////////////////////////////////////////////////////////
  sxd_match u_match (
    .insn (in_insn),
    .dec  (dec_d)
  );

  // take a new instruction only when the previous one has finished its clocks
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dec_q   <= '0;
      valid_q <= 1'b0;
    end else begin
      valid_q <= in_valid && !busy;
      if (in_valid && !busy) begin
        dec_q <= dec_d;
      end
    end
  end

  // execution clock countdown
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 6'h00;
    end else if (in_valid && !busy && dec_d.legal) begin
      cnt_q <= dec_d.clocks - 6'h01;
    end else if (cnt_q != 6'h00) begin
      cnt_q <= cnt_q - 6'h01;
    end
  end

  assign busy      = (cnt_q != 6'h00);
  assign out_valid = valid_q;
  assign out_dec   = dec_q;

  ////////////////////////////////////////////////////////////////////////////
  // a request taken at this edge with the given opcode byte
  sequence s_take(logic [7:0] f);
    in_valid && !busy && in_insn.first == f;
  endsequence

  // a taken request whose addressing byte names a register (1) or memory (0)
  sequence s_take_form(logic [7:0] f, logic reg_form);
    s_take(f) ##0 ((in_insn.modrm[7:6] == `SXD_MOD_REG) == reg_form);
  endsequence

  // a taken swap of either size, register (1) or memory (0) operand
  sequence s_take_swap(logic reg_form);
    in_valid && !busy && in_insn.first[7:1] == `SXD_OP_SWAP_HI
      && ((in_insn.modrm[7:6] == `SXD_MOD_REG) == reg_form);
  endsequence

  // a taken segment pull with any selector
  sequence s_take_segpop;
    in_valid && !busy && in_insn.first[7:5] == `SXD_SEGPOP_HI
      && in_insn.first[2:0] == `SXD_SEGPOP_LO;
  endsequence

  // last busy cycle of an accepted instruction, then free for the next one
  sequence s_release;
    busy ##1 !busy;
  endsequence

  // a refused form: flagged illegal and no execution clocks run
  sequence s_refused;
    !out_dec.legal && !busy;
  endsequence

  // stack pulls
  chk_pop_mem_time: assert property (@(posedge clk) disable iff (!nrst)
    s_take(`SXD_OP_POP_MEM) ##0 in_insn.modrm[5:3] == `SXD_REG_POP
      |=> out_dec.op == SXD_POP_MEM && out_dec.clocks == `SXD_CLK_POP_MEM ##22 s_release)
    else $error("pop memory decode or timing wrong");

  chk_pop_mem_other: assert property (@(posedge clk) disable iff (!nrst)
    s_take(`SXD_OP_POP_MEM) ##0 in_insn.modrm[5:3] != `SXD_REG_POP
      |=> out_dec.op == SXD_NONE ##0 s_refused)
    else $error("pop memory with nonzero middle field accepted");

  chk_pop_seg_bad: assert property (@(posedge clk) disable iff (!nrst)
    s_take_segpop ##0 in_insn.first[4:3] == `SXD_SEG_BAD
      |=> out_dec.op == SXD_POP_SEG ##0 s_refused)
    else $error("segment pull with selector 01 accepted");

  chk_pop_seg_time: assert property (@(posedge clk) disable iff (!nrst)
    s_take_segpop ##0 in_insn.first[4:3] != `SXD_SEG_BAD
      |=> out_dec.legal && out_dec.clocks == `SXD_CLK_POP_SEG ##10 s_release)
    else $error("segment pull timing wrong");

  chk_pop_seg_fields: assert property (@(posedge clk) disable iff (!nrst)
    s_take_segpop
      |=> out_dec.op == SXD_POP_SEG && out_dec.word && !out_dec.mem)
    else $error("segment pull fields wrong");

  // operand swaps and operand size bit
  chk_swap_reg_time: assert property (@(posedge clk) disable iff (!nrst)
    s_take_swap(1'b1)
      |=> out_dec.op == SXD_SWAP_OPERANDS && !out_dec.mem
        && out_dec.clocks == `SXD_CLK_SWAP_REG ##2 s_release)
    else $error("register swap decode or timing wrong");

  chk_swap_mem_time: assert property (@(posedge clk) disable iff (!nrst)
    s_take_swap(1'b0)
      |=> out_dec.op == SXD_SWAP_OPERANDS && out_dec.mem
        && out_dec.clocks == `SXD_CLK_SWAP_MEM ##15 s_release)
    else $error("memory swap decode or timing wrong");

  chk_size_bit: assert property (@(posedge clk) disable iff (!nrst)
    in_valid && !busy && in_insn.first[7:1] == `SXD_OP_SWAP_HI |=> out_dec.word == $past(in_insn.first[0]))
    else $error("size bit not honoured");

  chk_size_fixed: assert property (@(posedge clk) disable iff (!nrst)
    s_take(`SXD_OP_TABLE) or s_take(`SXD_OP_FL2AH) or s_take(`SXD_OP_AH2FL)
      |=> !out_dec.word)
    else $error("single size operation reported as word");

  // effective offset and far pointer loads
  chk_eo_reg_illegal: assert property (@(posedge clk) disable iff (!nrst)
    s_take_form(`SXD_OP_LOAD_EO, 1'b1)
      |=> out_dec.op == SXD_LOAD_EFFECTIVE_OFFSET ##0 s_refused)
    else $error("effective offset with register form accepted");

  chk_eo_mem_time: assert property (@(posedge clk) disable iff (!nrst)
    s_take_form(`SXD_OP_LOAD_EO, 1'b0)
      |=> out_dec.legal && out_dec.clocks == `SXD_CLK_LOAD_EO ##24 s_release)
    else $error("effective offset timing wrong");

  chk_fpd_mem_only: assert property (@(posedge clk) disable iff (!nrst)
    s_take_form(`SXD_OP_LOAD_FPD, 1'b1)
      |=> out_dec.op == SXD_LOAD_FAR_POINTER_DATA_SEGMENT ##0 s_refused)
    else $error("far pointer with register operand accepted");

  chk_fpd_mem_time: assert property (@(posedge clk) disable iff (!nrst)
    s_take_form(`SXD_OP_LOAD_FPD, 1'b0)
      |=> out_dec.legal && out_dec.clocks == `SXD_CLK_LOAD_FPD ##24 s_release)
    else $error("far pointer timing wrong");

  // single byte transfers
  chk_table_time: assert property (@(posedge clk) disable iff (!nrst)
    s_take(`SXD_OP_TABLE)
      |=> out_dec.op == SXD_TABLE_LOOKUP_BYTE && out_dec.clocks == `SXD_CLK_TABLE
        ##13 s_release)
    else $error("table lookup timing wrong");

  chk_fl2ah_time: assert property (@(posedge clk) disable iff (!nrst)
    s_take(`SXD_OP_FL2AH)
      |=> out_dec.op == SXD_FLAGS_INTO_HIGH_ACC && out_dec.clocks == `SXD_CLK_FL2AH
        ##0 s_release)
    else $error("flags to high byte timing wrong");

  chk_ah2fl_time: assert property (@(posedge clk) disable iff (!nrst)
    s_take(`SXD_OP_AH2FL)
      |=> out_dec.op == SXD_HIGH_ACC_INTO_FLAGS && out_dec.clocks == `SXD_CLK_AH2FL
        && busy ##1 s_release)
    else $error("high byte to flags timing wrong");

  // handshake and hold behaviour
  chk_take_pulse: assert property (@(posedge clk) disable iff (!nrst)
    in_valid && !busy |=> out_valid)
    else $error("taken request gave no result");

  chk_no_take_quiet: assert property (@(posedge clk) disable iff (!nrst)
    !(in_valid && !busy) |=> !out_valid)
    else $error("result shown without a taken request");

  chk_busy_hold: assert property (@(posedge clk) disable iff (!nrst)
    busy |=> $stable(out_dec))
    else $error("decode result changed while busy");

  chk_fields_follow: assert property (@(posedge clk) disable iff (!nrst)
    in_valid && !busy
      |=> out_dec.reg_f == $past(in_insn.modrm[5:3]) && out_dec.rm == $past(in_insn.modrm[2:0])
        && out_dec.seg == $past(in_insn.first[4:3]))
    else $error("operand fields not passed on");

  chk_illegal_idle: assert property (@(posedge clk) disable iff (!nrst)
    out_valid && !out_dec.legal |-> !busy)
    else $error("illegal form started execution clocks");

  // helper: length of the current busy stretch
  logic [5:0] busy_len_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_len_q <= 6'h00;
    end else if (busy) begin
      busy_len_q <= busy_len_q + 6'h01;
    end else begin
      busy_len_q <= 6'h00;
    end
  end

  chk_run_length: assert property (@(posedge clk) disable iff (!nrst)
    $fell(busy) |-> busy_len_q == out_dec.clocks - 6'h01)
    else $error("busy stretch does not match decoded clocks");
endmodule : sxd_decoder
`default_nettype wire

// File: rtl/sxd_defines.svh
// opcode patterns, field values and clock counts for the stack and transfer decoder
`ifndef SXD_DEFINES_SVH
`define SXD_DEFINES_SVH
`define SXD_OP_POP_MEM     8'h8f
`define SXD_OP_SWAP_HI     7'h43
`define SXD_OP_LOAD_EO     8'h8d
`define SXD_OP_LOAD_FPD    8'hc4
`define SXD_OP_TABLE       8'hd7
`define SXD_OP_FL2AH       8'h9f
`define SXD_OP_AH2FL       8'h9e
`define SXD_SEGPOP_HI      3'h0
`define SXD_SEGPOP_LO      3'h7
`define SXD_SEG_BAD        2'h1
`define SXD_MOD_REG        2'h3
`define SXD_REG_POP        3'h0
`define SXD_CLK_POP_MEM    6'h18
`define SXD_CLK_POP_SEG    6'h0c
`define SXD_CLK_SWAP_REG   6'h04
`define SXD_CLK_SWAP_MEM   6'h11
`define SXD_CLK_LOAD_EO    6'h1a
`define SXD_CLK_LOAD_FPD   6'h1a
`define SXD_CLK_TABLE      6'h0f
`define SXD_CLK_FL2AH      6'h02
`define SXD_CLK_AH2FL      6'h03
`endif

// File: rtl/sxd_pkg.sv
// types shared by the stack and transfer decoder
`default_nettype none
package sxd_pkg;
  typedef enum logic [3:0] {
    SXD_NONE, SXD_POP_MEM, SXD_POP_SEG, SXD_SWAP_OPERANDS, SXD_LOAD_EFFECTIVE_OFFSET,
    SXD_LOAD_FAR_POINTER_DATA_SEGMENT, SXD_TABLE_LOOKUP_BYTE, SXD_FLAGS_INTO_HIGH_ACC,
    SXD_HIGH_ACC_INTO_FLAGS
  } sxd_op_e;
  typedef struct packed {
    logic [7:0] first;
    logic [7:0] modrm;
  } sxd_insn_s;
  typedef struct packed {
    sxd_op_e    op;
    logic       legal;
    logic       word;
    logic       mem;
    logic [1:0] seg;
    logic [2:0] reg_f;
    logic [2:0] rm;
    logic [5:0] clocks;
  } sxd_dec_s;
endpackage : sxd_pkg
`default_nettype wire

// File: rtl/sxd_match.sv
// combinational opcode classifier
`timescale 1ns/100ps
`default_nettype none
`include "sxd_defines.svh"
module sxd_match
  import sxd_pkg::*;
(
  input  wire sxd_insn_s insn,
  output sxd_dec_s       dec
);
  function automatic logic is_mem(input logic [7:0] m);
    is_mem = (m[7:6] != `SXD_MOD_REG);
  endfunction : is_mem

  always_comb begin
    dec        = '0;
    dec.op     = SXD_NONE;
    dec.reg_f  = insn.modrm[5:3];
    dec.rm     = insn.modrm[2:0];
    dec.seg    = insn.first[4:3];
    dec.mem    = is_mem(insn.modrm);
    if (insn.first == `SXD_OP_POP_MEM && insn.modrm[5:3] == `SXD_REG_POP) begin
      dec.op     = SXD_POP_MEM;
      dec.legal  = 1'b1;
      dec.word   = 1'b1;
      dec.clocks = `SXD_CLK_POP_MEM;
    end else if (insn.first[7:5] == `SXD_SEGPOP_HI && insn.first[2:0] == `SXD_SEGPOP_LO) begin
      dec.op     = SXD_POP_SEG;
      dec.legal  = (insn.first[4:3] != `SXD_SEG_BAD);
      dec.word   = 1'b1;
      dec.mem    = 1'b0;
      dec.clocks = `SXD_CLK_POP_SEG;
    end else if (insn.first[7:1] == `SXD_OP_SWAP_HI) begin
      dec.op     = SXD_SWAP_OPERANDS;
      dec.legal  = 1'b1;
      dec.word   = insn.first[0];
      dec.clocks = is_mem(insn.modrm) ? `SXD_CLK_SWAP_MEM : `SXD_CLK_SWAP_REG;
    end else if (insn.first == `SXD_OP_LOAD_EO) begin
      dec.op     = SXD_LOAD_EFFECTIVE_OFFSET;
      dec.legal  = is_mem(insn.modrm);
      dec.word   = 1'b1;
      dec.clocks = `SXD_CLK_LOAD_EO;
    end else if (insn.first == `SXD_OP_LOAD_FPD) begin
      dec.op     = SXD_LOAD_FAR_POINTER_DATA_SEGMENT;
      dec.legal  = is_mem(insn.modrm);
      dec.word   = 1'b1;
      dec.clocks = `SXD_CLK_LOAD_FPD;
    end else if (insn.first == `SXD_OP_TABLE) begin
      dec.op     = SXD_TABLE_LOOKUP_BYTE;
      dec.legal  = 1'b1;
      dec.mem    = 1'b1;
      dec.clocks = `SXD_CLK_TABLE;
    end else if (insn.first == `SXD_OP_FL2AH) begin
      dec.op     = SXD_FLAGS_INTO_HIGH_ACC;
      dec.legal  = 1'b1;
      dec.mem    = 1'b0;
      dec.clocks = `SXD_CLK_FL2AH;
    end else if (insn.first == `SXD_OP_AH2FL) begin
      dec.op     = SXD_HIGH_ACC_INTO_FLAGS;
      dec.legal  = 1'b1;
      dec.mem    = 1'b0;
      dec.clocks = `SXD_CLK_AH2FL;
    end
  end
endmodule : sxd_match
`default_nettype wire

// File: tb/sxd_decoder_bench.sv
// self-checking bench for the stack and transfer decoder
`timescale 1ns/100ps
`default_nettype none
module sxd_decoder_bench
  import sxd_pkg::*;
;
  logic        clk             = 1'b0;
  logic        nrst            = 1'b0;
  logic        in_valid        = 1'b0;
  sxd_insn_s   in_insn         = '0;
  logic        out_valid;
  sxd_dec_s    out_dec;
  logic        busy;
  int          error_cnt       = 0;
  int          samples_checked = 0;
  int          cyc             = 0;
  logic [15:0] corner [16]     = '{16'h8f00, 16'h8f08, 16'h0700, 16'h0f00, 16'h1700, 16'h1f00,
    16'h86c0, 16'h8700, 16'h8dc0, 16'h8d45, 16'hc4c0, 16'hc480, 16'hd700, 16'h9f00, 16'h9e00,
    16'h0000};
  logic [7:0]  picks [8]       = '{8'h8f, 8'h0f, 8'h87, 8'h8d, 8'hc4, 8'hd7, 8'h9f, 8'h9e};

  always #12.5 clk = ~clk;

  sxd_decoder sxd_decoder_inst (.clk(clk), .nrst(nrst), .in_valid(in_valid), .in_insn(in_insn),
    .out_valid(out_valid), .out_dec(out_dec), .busy(busy));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // returns {op, legal, clocks}; zero for unknown or illegal forms
  function automatic logic [10:0] exp_fn(input logic [7:0] f, input logic [7:0] m);
    if (f == 8'h8f && m[5:3] == 3'h0) return {SXD_POP_MEM, 1'b1, 6'h18};
    if (f[7:5] == 3'h0 && f[2:0] == 3'h7)
      return f[4:3] == 2'h1 ? 11'h0 : {SXD_POP_SEG, 1'b1, 6'h0c};
    if (f[7:1] == 7'h43)
      return {SXD_SWAP_OPERANDS, 1'b1, m[7:6] == 2'h3 ? 6'h04 : 6'h11};
    if (m[7:6] == 2'h3 && (f == 8'h8d || f == 8'hc4)) return 11'h0;
    if (f == 8'h8d) return {SXD_LOAD_EFFECTIVE_OFFSET, 1'b1, 6'h1a};
    if (f == 8'hc4) return {SXD_LOAD_FAR_POINTER_DATA_SEGMENT, 1'b1, 6'h1a};
    if (f == 8'hd7) return {SXD_TABLE_LOOKUP_BYTE, 1'b1, 6'h0f};
    if (f == 8'h9f) return {SXD_FLAGS_INTO_HIGH_ACC, 1'b1, 6'h02};
    if (f == 8'h9e) return {SXD_HIGH_ACC_INTO_FLAGS, 1'b1, 6'h03};
    return 11'h0;
  endfunction : exp_fn

  // returns {word, mem} for legal forms
  function automatic logic [1:0] exp_wm(input logic [7:0] f, input logic [7:0] m);
    if (f[7:1] == 7'h43) return {f[0], m[7:6] != 2'h3};
    if (f[7:5] == 3'h0 && f[2:0] == 3'h7) return 2'h2;
    if (f == 8'hd7) return 2'h1;
    if (f == 8'h9f || f == 8'h9e) return 2'h0;
    return {1'b1, m[7:6] != 2'h3};
  endfunction : exp_wm

  // request stays up with junk bytes while busy, so refusal is exercised too
  task automatic run_one(input logic [7:0] f, input logic [7:0] m);
    logic [10:0] e;
    sxd_dec_s    held;
    int          n;
    e = exp_fn(f, m);
    n = 0;
    in_valid = 1'b1;
    in_insn = {f, m};
    @(negedge clk);
    held = out_dec;
    cmp(out_valid, 1'b1);
    cmp(out_dec.legal, e[6]);
    if (e[6]) cmp({out_dec.op, out_dec.clocks}, {e[10:7], e[5:0]});
    if (e[6]) cmp({out_dec.word, out_dec.mem}, exp_wm(f, m));
    cmp({out_dec.seg, out_dec.reg_f, out_dec.rm}, {f[4:3], m[5:0]});
    while (busy === 1'b1 && n < 64) begin
      in_insn = 16'($urandom);
      @(negedge clk);
      n++;
      cmp(out_valid, 1'b0);
    end
    cmp(n, e[6] ? int'(e[5:0]) - 1 : 0);
    cmp(out_dec, held);
  endtask : run_one

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  initial begin
    logic [7:0] f;
    void'($urandom(32'h20a0d917));
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    foreach (corner[i]) run_one(corner[i][15:8], corner[i][7:0]);
    $display("corner test done");
    in_insn = 16'h8f00;
    repeat (5) @(negedge clk);
    cmp(busy, 1'b1);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    cmp({busy, out_valid, out_dec}, 23'h0);
    nrst = 1'b1;
    $display("reset test done");
    repeat (300) begin
      f = picks[$urandom % 8];
      if ($urandom % 4 == 0) f = 8'($urandom);
      run_one(f, 8'($urandom));
    end
    in_valid = 1'b0;
    $display("random test done");
    complete_run();
  end
endmodule : sxd_decoder_bench
`default_nettype wire
